// *** design/external_bus_hold_handshake.sv ***
// Purpose: hold request / acknowledge arbitration of the external bus
// Assumes: inputs synchronous except the hold request, which is synced
// Notes: output enables are active low (low = device drives the pin)
// How it works
// - hold request floats address, data, strobes
// - disable bit set stops hold function
// - trip inputs ignored until software enables
// - grant only after access done, none pending
// - pin fifteen: input trip four, output acknowledge
// - acknowledge low only after bus floated
// - request released: drop acknowledge, drive bus
`timescale 1ns/1ps
`include "hold_consts.svh"
module external_bus_hold_handshake
#(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 32,
    parameter int STROBE_W = 8
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // configuration from software-owned control bits
    input wire hold_pkg::hold_cfg_t cfg,
    // external bus interface status
    input wire logic access_busy,
    input wire logic access_pending,
    // shared pin fourteen: trip three / hold request
    input wire logic shared_pin_fourteen,
    // shared pin fifteen: trip four / acknowledge
    input wire logic shared_pin_fifteen_in,
    output logic shared_pin_fifteen_out,
    output logic shared_pin_fifteen_oe_n,
    // bus release and status
    output logic bus_addr_oe_n,
    output logic bus_data_oe_n,
    output logic bus_strobe_oe_n,
    output logic bus_held,
    output logic bus_grant_ack_n,
    output logic block_new_access,
    // trip inputs towards the pwm module
    output logic [1:0] trip_inputs
);
    hold_pkg::hold_state_t state;
    hold_pkg::hold_state_t next_state;
    logic req_sync_n;
    logic ack_n;
    logic next_ack_n;
    logic float_bus;
    logic next_float_bus;
    logic hold_req;
    logic pin15_is_out;

    // the request pin is asynchronous; a raw glitch must not half-release
    hold_sync u_sync
    (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .d_in(shared_pin_fourteen),
        .d_out(req_sync_n)
    );

    assign hold_req = !req_sync_n && !cfg.hold_disable;
    assign pin15_is_out = (cfg.pin15_dir == `DIR_OUTPUT);

    always_comb
    begin
        next_state = state;
        next_float_bus = float_bus;
        next_ack_n = ack_n;
        case (state)
            hold_pkg::st_idle:
            begin
                if (hold_req)
                    next_state = hold_pkg::st_drain;
            end
            hold_pkg::st_drain:
            begin
                if (!hold_req)
                    next_state = hold_pkg::st_idle;
                else if (!access_busy && !access_pending)
                begin
                    next_float_bus = 1'b1;
                    next_state = hold_pkg::st_held;
                end
            end
            hold_pkg::st_held:
            begin
                // ack one cycle after the float so it never leads it
                next_ack_n = !hold_req;
                if (!hold_req)
                    next_state = hold_pkg::st_release;
            end
            hold_pkg::st_release:
            begin
                // ack already high here; the master stops before we drive
                next_ack_n = 1'b1;
                next_float_bus = 1'b0;
                next_state = hold_pkg::st_idle;
            end
            default:
            begin
                next_state = hold_pkg::st_idle;
                next_float_bus = 1'b0;
                next_ack_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= hold_pkg::st_idle;
            float_bus <= 1'b0;
            ack_n <= 1'b1;
        end
        else
        begin
            state <= next_state;
            float_bus <= next_float_bus;
            ack_n <= next_ack_n;
        end
    end

    assign bus_addr_oe_n = float_bus;
    assign bus_data_oe_n = float_bus;
    assign bus_strobe_oe_n = float_bus;
    assign bus_held = float_bus;
    // stop issuing new accesses as soon as a hold is being drained
    assign block_new_access = (state != hold_pkg::st_idle);
    assign bus_grant_ack_n = ack_n;

    assign shared_pin_fifteen_out = ack_n;
    assign shared_pin_fifteen_oe_n = !pin15_is_out;

    // trips are active low; a disabled trip reads as inactive
    function automatic logic trip_gate(input logic allowed,
        input logic pin_n);
        trip_gate = allowed && !pin_n;
    endfunction

    // trip three is taken raw: the pwm side wants the fastest response
    logic [1:0] trip_raw_n;
    logic [1:0] trip_allowed;
    assign trip_raw_n[0] = shared_pin_fourteen;
    assign trip_raw_n[1] = shared_pin_fifteen_in;
    assign trip_allowed[0] = cfg.trip_enable[0];
    // pin fifteen only trips while it is an input
    assign trip_allowed[1] = cfg.trip_enable[1] && !pin15_is_out;

    genvar t;
    generate
        for (t = 0; t < 2; t++)
        begin : g_trip
            assign trip_inputs[t] =
                trip_gate(trip_allowed[t], trip_raw_n[t]);
        end
    endgenerate
endmodule

// *** design/hold_consts.svh ***
// Purpose: constants for the external bus hold handshake
// Assumes: single 40 MHz clock
// Notes: widths of the released bus are module parameters
`ifndef HOLD_CONSTS_SVH
`define HOLD_CONSTS_SVH
`define HOLD_SYNC_STAGES 2
`define HOLD_DISABLE_RESET 1'b0
`define TRIP_ENABLE_RESET 2'h0
`define DIR_OUTPUT 1'b1
`endif

// *** design/hold_pkg.sv ***
// Purpose: types for the external bus hold handshake
// Assumes: nothing beyond the constants header
// Notes: states are gray coded along idle-drain-held-release
package hold_pkg;
    typedef enum logic [1:0] {
        st_idle = 2'h0,
        st_drain = 2'h1,
        st_held = 2'h3,
        st_release = 2'h2
    } hold_state_t;

    typedef struct packed {
        logic hold_disable;
        logic [1:0] trip_enable;
        logic pin15_dir;
    } hold_cfg_t;
endpackage

// *** design/hold_sync.sv ***
// Purpose: two-flop synchroniser for the hold request pin
// Assumes: input may be asynchronous
// Notes: resets to the inactive (high) level
`timescale 1ns/1ps
module hold_sync
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // level in and out
    input wire logic d_in,
    output logic d_out
);
    logic stage_a;
    logic stage_b;
    logic next_stage_a;
    logic next_stage_b;

    always_comb
    begin
        next_stage_a = d_in;
        next_stage_b = stage_a;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stage_a <= 1'b1;
            stage_b <= 1'b1;
        end
        else
        begin
            stage_a <= next_stage_a;
            stage_b <= next_stage_b;
        end
    end

    assign d_out = stage_b;
endmodule

// *** dv/bus_master_model.sv ***
// Purpose: outside bus master
// Assumes: grant seen on ack_n
// Notes: request follows want
`timescale 1ns/1ps
module bus_master_model (
    input wire logic ref_clk, want, ack_n,
    output logic req_n, drive_bus
);
    // moves after the rising edge, clear of bench stimulus
    initial req_n = 1'b1;
    always @(posedge ref_clk) req_n <= !want;
    assign drive_bus = !ack_n && !req_n;
endmodule

// *** dv/external_bus_hold_handshake_test.sv ***
// Purpose: hold bench
// Assumes: 40 MHz clock
// Notes: rows, then reset cases
`timescale 1ns/1ps
module external_bus_hold_handshake_test;
    logic ref_clk = 1'b0, rstn = 1'b0, busy = 1'b0, pend = 1'b0;
    logic want = 1'b0, p15 = 1'b1;
    logic pin14, p15_oe_n, a_oe, d_oe, s_oe, held, ack_n, blk, p15_out;
    logic [1:0] trip;
    logic [4:0] exp;
    hold_pkg::hold_cfg_t cfg = 4'h0;
    int fails = 0, num_checks = 0, cyc = 0;
    logic [12:0] rows [8] = '{13'h0270, 13'h0228, 13'h1268, 13'h166a,
        13'h180d, 13'h0368, 13'h02e8, 13'h0270};
    external_bus_hold_handshake i_external_bus_hold_handshake (
        .ref_clk, .rstn, .cfg, .access_busy(busy), .access_pending(pend),
        .shared_pin_fourteen(pin14), .shared_pin_fifteen_in(p15),
        .shared_pin_fifteen_out(p15_out), .shared_pin_fifteen_oe_n(p15_oe_n),
        .bus_addr_oe_n(a_oe), .bus_data_oe_n(d_oe), .bus_strobe_oe_n(s_oe),
        .bus_held(held), .bus_grant_ack_n(ack_n), .block_new_access(blk),
        .trip_inputs(trip));
    bus_master_model i_bus_master_model (.ref_clk, .want, .ack_n,
        .req_n(pin14), .drive_bus());
    initial forever #12.5 ref_clk = !ref_clk;
    task automatic check(input logic [4:0] seen, input logic [4:0] want_v);
        num_checks++;
        if (seen !== want_v)
        begin
            fails++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, want_v);
        end
    endtask
    task automatic conclude();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 400)
        begin
            fails++;
            conclude();
        end
    end
    initial
    begin
        repeat (10) @(negedge ref_clk);
        check({a_oe, d_oe, s_oe, held, ack_n}, 5'h01);
        rstn = 1'b1;
        // row: cfg, busy, pending, want, pin15 in, then held, ack, trip, oe
        foreach (rows[i])
        begin
            {cfg, busy, pend, want, p15, exp} = rows[i];
            repeat (8) @(negedge ref_clk);
            check({held, ack_n, trip, p15_oe_n}, exp);
        end
        check({a_oe, d_oe, s_oe, held, ack_n}, 5'h1e);
        // reset in mid-hold must drive the bus again at once
        rstn = 1'b0;
        #1 check({a_oe, d_oe, s_oe, held, ack_n}, 5'h01);
        @(negedge ref_clk) rstn = 1'b1;
        repeat (8) @(negedge ref_clk);
        check({a_oe, d_oe, s_oe, held, ack_n}, 5'h1e);
        check({blk, p15_out, 3'h0}, 5'h10);
        conclude();
    end
endmodule

// *** dv/external_bus_hold_monitor.sv ***
// Purpose: hold checks
// Assumes: top ports
// Notes: one clock
`timescale 1ns/1ps
module external_bus_hold_monitor (
    input wire logic ref_clk, rstn, access_busy, access_pending,
    input wire hold_pkg::hold_cfg_t cfg,
    input wire logic shared_pin_fourteen, shared_pin_fifteen_out,
    input wire logic shared_pin_fifteen_oe_n, bus_addr_oe_n,
    input wire logic bus_data_oe_n, bus_strobe_oe_n, bus_held,
    input wire logic bus_grant_ack_n, block_new_access,
    input wire logic [1:0] trip_inputs
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_float_all: assert property (
        {bus_addr_oe_n, bus_data_oe_n, bus_strobe_oe_n} == {3{bus_held}}
    ) else $error("float");
    a_disable_idle: assert property (
        cfg.hold_disable && !block_new_access |=> !block_new_access
    ) else $error("disable");
    a_trip_gated: assert property (
        (trip_inputs & ~cfg.trip_enable) == 2'h0) else $error("trip");
    a_wait_access: assert property (
        (access_busy || access_pending) && !bus_held |=> !bus_held
    ) else $error("busy");
    a_pin_role: assert property (
        shared_pin_fifteen_oe_n == !cfg.pin15_dir &&
        shared_pin_fifteen_out == bus_grant_ack_n) else $error("pin");
    a_ack_after: assert property (
        $fell(bus_grant_ack_n) |-> $past(bus_held) && bus_held
    ) else $error("ack");
    a_release_ack: assert property (
        shared_pin_fourteen[*2] ##0 !bus_grant_ack_n
        |=> ##1 bus_grant_ack_n ##1 !bus_held) else $error("release");
    a_sync_first: assert property (
        $fell(shared_pin_fourteen) && !block_new_access
        |=> !block_new_access) else $error("sync");
endmodule
bind external_bus_hold_handshake external_bus_hold_monitor i_mon (.*);
